/* File: lmc_defs.vh */
// Timing constants and mode codes for the single-wire transceiver mode controller
`ifndef LMC_DEFS_VH
`define LMC_DEFS_VH

// Clock rate in MHz
`define LMC_CLK_MHZ 20

// Times as given
`define LMC_T_RESET_US 4000
`define LMC_T_DOM_US 20000
`define LMC_T_TXHI_NS 10000
`define LMC_T_SEL_NS 3200
`define LMC_T_WAKE_US 100

// Cycle counts at the clock rate, sized to their counters
`define LMC_RESET_CYC 17'h13880
`define LMC_DOM_CYC 19'h61A80
`define LMC_TXHI_CYC 8'hC8
`define LMC_SEL_CYC 7'h40
`define LMC_WAKE_CYC 11'h7D0

// Counter widths
`define LMC_RESET_W 17
`define LMC_DOM_W 19
`define LMC_TXHI_W 8
`define LMC_SEL_W 7
`define LMC_WAKE_W 11

// One-hot mode codes
`define LMC_MODE_W 5
`define LMC_ST_FAILSAFE 5'h01
`define LMC_ST_NORMAL 5'h02
`define LMC_ST_SILENT 5'h04
`define LMC_ST_SLEEP 5'h08
`define LMC_ST_SELECT 5'h10

// Synchronised input bit positions
`define LMC_SYN_N 7
`define LMC_SYN_EN 0
`define LMC_SYN_EN_FLOAT 1
`define LMC_SYN_TXD 2
`define LMC_SYN_BUS 3
`define LMC_SYN_PREWAKE 4
`define LMC_SYN_VCC_UV 5
`define LMC_SYN_VS_UV 6

`endif

/* File: lmc_sync.v */
// Two-flop synchroniser bank for the pin-level inputs
`timescale 1ns/1ns
module lmc_sync #(
  parameter N = 7
) (
  // Clock and reset
  input wire clock_i,
  input wire rstn_i,
  // Data
  input wire [N-1:0] d_i,
  output wire [N-1:0] q_o
);
  reg [N-1:0] meta_r;
  reg [N-1:0] sync_r;
  genvar g;
  generate
    for (g = 0; g < N; g = g + 1) begin : g_bit
      // First stage feeds only the second stage
      always @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) begin
          meta_r[g] <= 1'b0;
          sync_r[g] <= 1'b0;
        end else begin
          meta_r[g] <= d_i[g];
          sync_r[g] <= meta_r[g];
        end
      end
    end
  endgenerate
  assign q_o = sync_r;
endmodule // lmc_sync

/* File: lmc_timer.v */
// Saturating interval timer with clear and run controls
`timescale 1ns/1ns
module lmc_timer #(
  parameter W = 8,
  parameter [W-1:0] LIMIT = {W{1'b1}}
) (
  // Clock and reset
  input wire clock_i,
  input wire rstn_i,
  // Control
  input wire clr_i,
  input wire run_i,
  // Status
  output reg done_o
);
  reg [W-1:0] cnt_r;
  always @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      cnt_r <= {W{1'b0}};
      done_o <= 1'b0;
    end else if (clr_i) begin
      cnt_r <= {W{1'b0}};
      done_o <= 1'b0;
    end else if (run_i && !done_o) begin
      // Saturate so a held condition never wraps
      cnt_r <= cnt_r + {{(W-1){1'b0}}, 1'b1};
      done_o <= (cnt_r == LIMIT - {{(W-1){1'b0}}, 1'b1});
    end
  end
endmodule // lmc_timer

/* File: lmc_mode_ctrl.v */
// Mode controller for a single-wire bus transceiver with integrated regulator
// Functional notes
// R1: Normal mode: receive output follows bus level
// R2: Silent mode: receive output held high
// R3: Enable high selects normal mode, paths active
// R4: Enable falls, transmit high: silent mode
// R5: Enable falls, transmit low: sleep, regulator off
// R6: Transmit may fall 3.2us after enable
// R7: Floating enable is treated as low
// R8: Regulator undervoltage: reset low, fail-safe
// R9: Silent/sleep entry ignores bus level
// R10: Sleep: prewake level enables receiver, timer
// R11: Stuck transmit: sleep only after timeout
// R12: Power-up: fail-safe, reset low 4ms
// R13: Fail-safe until enable high, then normal
// R14: Reset output low forces fail-safe
// R15: Supply-undervoltage fail-safe: enable fall selects mode
// R16: Fail-safe source shown on transmit, receive
// R17: Silent wake-up only with transmit high
// R18: Long dominant pulse is remote wake-up
// R19: Wake-up: regulator, termination on, signal low
// R20: Enable high after reset delay: normal
// R21: Transmit low over 20ms releases driver
// R22: Transmit low at entry blocks driver 10us
// R23: Mode changes ignored during reset delay
// R24: Inputs synchronised before edge detection
`timescale 1ns/1ns
`include "lmc_defs.vh"
module lmc_mode_ctrl #(
  parameter [`LMC_RESET_W-1:0] RESET_CYC = `LMC_RESET_CYC,
  parameter [`LMC_DOM_W-1:0] DOM_CYC = `LMC_DOM_CYC
) (
  // Clock and reset
  input wire clock_i,
  input wire rstn_i,
  // Host pins
  input wire en_i,
  input wire en_float_i,
  input wire txd_i,
  output reg txd_o,
  output reg txd_oe_o,
  output reg rxd_o,
  output reg reset_out_n_o,
  output reg reset_out_n_oe_o,
  // Bus side
  input wire bus_i,
  input wire prewake_threshold_i,
  output reg bus_drv_o,
  output reg term_on_o,
  output reg rx_on_o,
  // Supply monitors and regulator
  input wire vcc_uv_i,
  input wire vs_uv_i,
  output reg reg_on_o,
  // Status
  output reg [`LMC_MODE_W-1:0] mode_o
);
  localparam [`LMC_MODE_W-1:0] ST_FS = `LMC_ST_FAILSAFE;
  localparam [`LMC_MODE_W-1:0] ST_NORM = `LMC_ST_NORMAL;
  localparam [`LMC_MODE_W-1:0] ST_SIL = `LMC_ST_SILENT;
  localparam [`LMC_MODE_W-1:0] ST_SLP = `LMC_ST_SLEEP;
  localparam [`LMC_MODE_W-1:0] ST_SEL = `LMC_ST_SELECT;

  wire [`LMC_SYN_N-1:0] syn;
  wire en_s;
  wire txd_s;
  wire bus_s;
  wire prewake_s;
  wire vcc_uv_s;
  wire vs_uv_s;
  wire en_fall;
  wire rst_done;
  wire dom_to;
  wire txhi_done;
  wire txlo_long;
  wire sel_done;
  wire wake_long;
  wire wake_ok;
  wire sleep_ok;
  wire reg_on_w;

  reg [`LMC_MODE_W-1:0] state_r;
  reg [`LMC_MODE_W-1:0] state_nxt;
  reg en_d_r;
  reg bus_d_r;
  reg src_wake_r;
  reg src_wake_nxt;
  reg src_uv_r;
  reg src_uv_nxt;
  reg drv_blk_r;
  reg drv_blk_nxt;
  reg sleep_pend_r;
  reg sleep_pend_nxt;
  reg wake_arm_r;
  reg wake_arm_nxt;
  reg rx_wake_r;
  reg rx_wake_nxt;
  reg rxd_nxt;

  // Active when the mode code is one of the given states
  function in_state;
    input [`LMC_MODE_W-1:0] st;
    input [`LMC_MODE_W-1:0] want;
    begin
      in_state = |(st & want);
    end
  endfunction

  lmc_sync #(
    .N(`LMC_SYN_N)
  ) u_sync (
    .clock_i(clock_i),
    .rstn_i(rstn_i),
    .d_i({vs_uv_i, vcc_uv_i, prewake_threshold_i, bus_i, txd_i, en_float_i, en_i}),
    .q_o(syn)
  ); // [R24]

  // Pull-down: a floating enable reads as low
  assign en_s = syn[`LMC_SYN_EN] & ~syn[`LMC_SYN_EN_FLOAT]; // [R7]
  assign txd_s = syn[`LMC_SYN_TXD];
  assign bus_s = syn[`LMC_SYN_BUS];
  assign prewake_s = syn[`LMC_SYN_PREWAKE];
  assign vcc_uv_s = syn[`LMC_SYN_VCC_UV];
  assign vs_uv_s = syn[`LMC_SYN_VS_UV];
  assign en_fall = en_d_r & ~en_s; // [R24]
  assign reg_on_w = ~in_state(state_r, ST_SLP);

  // Reset delay runs only with the regulator up and above threshold
  lmc_timer #(
    .W(`LMC_RESET_W),
    .LIMIT(RESET_CYC)
  ) u_rst_tmr (
    .clock_i(clock_i),
    .rstn_i(rstn_i),
    .clr_i(vcc_uv_s | ~reg_on_w),
    .run_i(1'b1),
    .done_o(rst_done)
  ); // [R12] [R8]

  // Dominant timeout on a held-low transmit input
  lmc_timer #(
    .W(`LMC_DOM_W),
    .LIMIT(DOM_CYC)
  ) u_dom_tmr (
    .clock_i(clock_i),
    .rstn_i(rstn_i),
    .clr_i(txd_s),
    .run_i(in_state(state_r, ST_NORM)),
    .done_o(dom_to)
  ); // [R21]

  // Transmit high time before the driver is re-armed
  lmc_timer #(
    .W(`LMC_TXHI_W),
    .LIMIT(`LMC_TXHI_CYC)
  ) u_txhi_tmr (
    .clock_i(clock_i),
    .rstn_i(rstn_i),
    .clr_i(~txd_s),
    .run_i(1'b1),
    .done_o(txhi_done)
  ); // [R22]

  // Transmit low longer than the select window counts as stuck
  lmc_timer #(
    .W(`LMC_SEL_W),
    .LIMIT(`LMC_SEL_CYC)
  ) u_txlo_tmr (
    .clock_i(clock_i),
    .rstn_i(rstn_i),
    .clr_i(txd_s),
    .run_i(1'b1),
    .done_o(txlo_long)
  ); // [R11]

  // Select window after enable falls with transmit still high
  lmc_timer #(
    .W(`LMC_SEL_W),
    .LIMIT(`LMC_SEL_CYC)
  ) u_sel_tmr (
    .clock_i(clock_i),
    .rstn_i(rstn_i),
    .clr_i(~in_state(state_r, ST_SEL)),
    .run_i(1'b1),
    .done_o(sel_done)
  ); // [R6]

  // Bus dominant time since the falling edge
  lmc_timer #(
    .W(`LMC_WAKE_W),
    .LIMIT(`LMC_WAKE_CYC)
  ) u_wake_tmr (
    .clock_i(clock_i),
    .rstn_i(rstn_i),
    .clr_i(bus_s | ~wake_arm_r),
    .run_i(1'b1),
    .done_o(wake_long)
  ); // [R18]

  // Silent wake-up only counts with transmit high
  assign wake_ok = in_state(state_r, ST_SLP) | (in_state(state_r, ST_SIL) & txd_s); // [R17]
  // A simultaneous fall is fine; a long-stuck low waits for the timeout
  assign sleep_ok = ~txlo_long | dom_to | ~in_state(state_r, ST_NORM); // [R11]

  always @* begin
    state_nxt = state_r;
    src_wake_nxt = src_wake_r;
    src_uv_nxt = src_uv_r;
    drv_blk_nxt = drv_blk_r;
    sleep_pend_nxt = sleep_pend_r;
    wake_arm_nxt = wake_arm_r;
    rx_wake_nxt = rx_wake_r;
    // Re-arm the driver once transmit has been high long enough
    if (txhi_done) begin
      drv_blk_nxt = 1'b0; // [R22] [R21]
    end
    if (in_state(state_r, ST_NORM) && dom_to) begin
      drv_blk_nxt = 1'b1; // [R21]
    end
    // Prewake level opens the receiver; falling edge arms the filter
    if (wake_ok && prewake_s) begin
      rx_wake_nxt = 1'b1; // [R10]
    end
    // Prewake and the falling edge may arrive in the same cycle
    if (wake_ok && (rx_wake_r || prewake_s) && bus_d_r && !bus_s) begin
      wake_arm_nxt = 1'b1; // [R18]
    end
    if (!wake_ok) begin
      rx_wake_nxt = 1'b0;
      wake_arm_nxt = 1'b0;
    end
    case (state_r)
      ST_NORM: begin
        if (vcc_uv_s || !rst_done) begin
          state_nxt = ST_FS; // [R8] [R14]
        end else if (vs_uv_s) begin
          state_nxt = ST_FS;
          src_uv_nxt = 1'b1; // [R15] [R16]
        end else if (en_fall && txd_s) begin
          state_nxt = ST_SEL; // [R4] [R9]
        end else if (en_fall && sleep_ok) begin
          state_nxt = ST_SLP; // [R5] [R9]
        end else if (en_fall) begin
          sleep_pend_nxt = 1'b1; // [R11]
        end else if (sleep_pend_r && !en_s) begin
          if (dom_to) begin
            state_nxt = ST_SLP;
            sleep_pend_nxt = 1'b0; // [R11]
          end
        end else begin
          sleep_pend_nxt = 1'b0;
        end
      end
      ST_SEL: begin
        // Transmit may follow enable down within the window
        if (vcc_uv_s || !rst_done) begin
          state_nxt = ST_FS; // [R14]
        end else if (!txd_s) begin
          state_nxt = ST_SLP; // [R6] [R5]
        end else if (sel_done) begin
          state_nxt = ST_SIL; // [R4]
        end
      end
      ST_SIL: begin
        if (vcc_uv_s || !rst_done) begin
          state_nxt = ST_FS; // [R8] [R14]
        end else if (wake_arm_r && wake_long && bus_s) begin
          state_nxt = ST_FS;
          src_wake_nxt = 1'b1; // [R18] [R19]
        end else if (en_s) begin
          state_nxt = ST_NORM; // [R3]
          drv_blk_nxt = ~txd_s; // [R22]
        end
      end
      ST_SLP: begin
        // Reset output is low here by design, so it does not force fail-safe
        if (wake_arm_r && wake_long && bus_s) begin
          state_nxt = ST_FS;
          src_wake_nxt = 1'b1; // [R18] [R19]
        end
      end
      ST_FS: begin
        if (!rst_done) begin
          state_nxt = ST_FS; // [R23]
        // Supply still low keeps fail-safe, else it bounces via normal
        end else if (en_s && !vcc_uv_s && !vs_uv_s) begin
          state_nxt = ST_NORM; // [R13] [R20] [R3]
          src_wake_nxt = 1'b0;
          src_uv_nxt = 1'b0;
          sleep_pend_nxt = 1'b0;
          drv_blk_nxt = ~txd_s; // [R22]
        end else if (en_fall && src_uv_r) begin
          state_nxt = txd_s ? ST_SEL : ST_SLP; // [R15]
          src_uv_nxt = 1'b0;
        end
      end
      default: begin
        state_nxt = ST_FS;
      end
    endcase
  end

  always @* begin
    case (state_r)
      ST_NORM: rxd_nxt = bus_s; // [R1]
      ST_SIL: rxd_nxt = 1'b1; // [R2]
      ST_SEL: rxd_nxt = 1'b1;
      ST_SLP: rxd_nxt = 1'b0; // [R5]
      ST_FS: rxd_nxt = ~(src_wake_r | src_uv_r); // [R16]
      default: rxd_nxt = 1'b1;
    endcase
  end

  always @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      state_r <= ST_FS; // [R12]
      en_d_r <= 1'b0;
      bus_d_r <= 1'b0;
      src_wake_r <= 1'b0;
      src_uv_r <= 1'b0;
      drv_blk_r <= 1'b1;
      sleep_pend_r <= 1'b0;
      wake_arm_r <= 1'b0;
      rx_wake_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      en_d_r <= en_s;
      bus_d_r <= bus_s;
      src_wake_r <= src_wake_nxt;
      src_uv_r <= src_uv_nxt;
      drv_blk_r <= drv_blk_nxt;
      sleep_pend_r <= sleep_pend_nxt;
      wake_arm_r <= wake_arm_nxt;
      rx_wake_r <= rx_wake_nxt;
    end
  end

  // All outputs registered; one cycle behind the state
  always @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      txd_o <= 1'b0;
      txd_oe_o <= 1'b0;
      rxd_o <= 1'b0;
      reset_out_n_o <= 1'b0;
      reset_out_n_oe_o <= 1'b1;
      bus_drv_o <= 1'b0;
      term_on_o <= 1'b0;
      rx_on_o <= 1'b0;
      reg_on_o <= 1'b1;
      mode_o <= ST_FS;
    end else begin
      mode_o <= state_r;
      rxd_o <= rxd_nxt;
      // Wake-up source wins over undervoltage on the transmit pin
      txd_oe_o <= in_state(state_r, ST_FS) & (src_wake_r | src_uv_r); // [R16]
      txd_o <= in_state(state_r, ST_FS) & src_uv_r & ~src_wake_r; // [R16] [R19]
      reset_out_n_o <= 1'b0;
      reset_out_n_oe_o <= ~rst_done | ~reg_on_w; // [R8] [R12] [R5]
      bus_drv_o <= in_state(state_r, ST_NORM) & ~txd_s & ~drv_blk_r & ~dom_to; // [R3] [R21]
      term_on_o <= in_state(state_r, ST_NORM | ST_FS); // [R19]
      rx_on_o <= in_state(state_r, ST_NORM) | rx_wake_r; // [R10]
      reg_on_o <= reg_on_w; // [R5] [R19]
    end
  end
endmodule // lmc_mode_ctrl

/* File: lmc_checker.sv */
// Concurrent checks on the mode controller ports
`timescale 1ns/1ns
`include "lmc_defs.vh"
module lmc_checker #(
  parameter RESET_CYC = 50,
  parameter DOM_CYC = 300
) (
  // Clock and reset
  input wire clock_i,
  input wire rstn_i,
  // Inputs
  input wire en_i,
  input wire en_float_i,
  input wire txd_i,
  input wire bus_i,
  input wire vcc_uv_i,
  // Outputs
  input wire txd_o,
  input wire txd_oe_o,
  input wire rxd_o,
  input wire reset_out_n_oe_o,
  input wire bus_drv_o,
  input wire term_on_o,
  input wire reg_on_o,
  input wire [`LMC_MODE_W-1:0] mode_o
);
  int rcnt_r;
  int tcnt_r;
  // Counters saturate so long runs cannot wrap
  always @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rcnt_r <= 0;
      tcnt_r <= 0;
    end else begin
      if (rcnt_r < RESET_CYC) rcnt_r <= rcnt_r + 1;
      if (txd_i) tcnt_r <= 0;
      else if (tcnt_r < DOM_CYC + 9) tcnt_r <= tcnt_r + 1;
    end
  end
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rstn_i);
  property p_rx_normal;
    (mode_o == `LMC_ST_NORMAL && $stable(bus_i)) [*6] |-> rxd_o == bus_i;
  endproperty
  a_rx_normal: assert property (p_rx_normal) else $error("rxd not following bus");
  property p_rx_silent;
    mode_o == `LMC_ST_SILENT && $past(mode_o) == `LMC_ST_SILENT |-> rxd_o;
  endproperty
  a_rx_silent: assert property (p_rx_silent) else $error("rxd low in silent");
  property p_sleep;
    mode_o == `LMC_ST_SLEEP && $past(mode_o) == `LMC_ST_SLEEP
      |-> !rxd_o && !reg_on_o && reset_out_n_oe_o;
  endproperty
  a_sleep: assert property (p_sleep) else $error("sleep outputs wrong");
  property p_rst_hold;
    rcnt_r < RESET_CYC |-> reset_out_n_oe_o && mode_o == `LMC_ST_FAILSAFE;
  endproperty
  a_rst_hold: assert property (p_rst_hold) else $error("reset delay cut short");
  property p_uv;
    mode_o == `LMC_ST_NORMAL && vcc_uv_i
      |-> ##[1:8] (mode_o == `LMC_ST_FAILSAFE && reset_out_n_oe_o);
  endproperty
  a_uv: assert property (p_uv) else $error("no fail-safe on undervoltage");
  property p_wake;
    mode_o == `LMC_ST_FAILSAFE && $past(mode_o) == `LMC_ST_SLEEP
      |-> ##[0:2] (txd_oe_o && !txd_o && !rxd_o && reg_on_o && term_on_o);
  endproperty
  a_wake: assert property (p_wake) else $error("wake signalling wrong");
  property p_dom;
    tcnt_r > DOM_CYC + 6 |-> !bus_drv_o;
  endproperty
  a_dom: assert property (p_dom) else $error("driver kept past timeout");
  property p_drv;
    bus_drv_o |-> mode_o == `LMC_ST_NORMAL;
  endproperty
  a_drv: assert property (p_drv) else $error("driver on outside normal");
  property p_en_low;
    (mode_o == `LMC_ST_FAILSAFE && (en_float_i || !en_i)) [*4] |=> mode_o != `LMC_ST_NORMAL;
  endproperty
  a_en_low: assert property (p_en_low) else $error("normal without enable");
  property p_rst_fs;
    reset_out_n_oe_o && mode_o != `LMC_ST_SLEEP |-> ##[0:1] mode_o == `LMC_ST_FAILSAFE;
  endproperty
  a_rst_fs: assert property (p_rst_fs) else $error("reset low outside fail-safe");
  c_sleep: cover property (mode_o == `LMC_ST_SLEEP);
  c_silent: cover property (mode_o == `LMC_ST_SILENT);
  c_wake: cover property (txd_oe_o && !txd_o);
endmodule // lmc_checker
bind lmc_mode_ctrl lmc_checker #(.RESET_CYC(RESET_CYC), .DOM_CYC(DOM_CYC)) chk_u (
  .clock_i, .rstn_i, .en_i, .en_float_i, .txd_i, .bus_i, .vcc_uv_i, .txd_o, .txd_oe_o,
  .rxd_o, .reset_out_n_oe_o, .bus_drv_o, .term_on_o, .reg_on_o, .mode_o);

/* File: lmc_far_model.sv */
// Host pin and bus line model at the far side of the mode controller
`timescale 1ns/1ns
module lmc_far_model (
  // Host and remote node
  input wire host_txd_i,
  input wire remote_dom_i,
  // Device side
  input wire txd_o_i,
  input wire txd_oe_i,
  input wire bus_drv_i,
  // Resolved lines
  output wire txd_pin_o,
  output wire bus_o,
  output wire prewake_o
);
  // Strong device drive overrides the host
  assign txd_pin_o = txd_oe_i ? txd_o_i : host_txd_i;
  // Pull-up keeps the bus recessive when nobody drives
  assign bus_o = ~(bus_drv_i | remote_dom_i);
  assign prewake_o = ~bus_o;
endmodule // lmc_far_model

/* File: lin_transceiver_mode_control_tb.sv */
// Self-checking testbench for the transceiver mode controller
`timescale 1ns/1ns
`include "lmc_defs.vh"
`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin miscompares++; \
  $display("[FAIL] %s expected %0h seen %0h", nm, e, g); end end
module lin_transceiver_mode_control_tb;
  localparam bit [16:0] RC = 17'd50;
  localparam bit [18:0] DC = 19'd300;
  reg clock_i = 0;
  reg rstn_i = 0;
  reg en_i = 0;
  reg en_float_i = 0;
  reg host_txd = 1;
  reg remote_dom = 0;
  reg vcc_uv_i = 0;
  reg vs_uv_i = 0;
  int miscompares = 0;
  int checks_done = 0;
  wire txd_i, bus_i, prewake_threshold_i, txd_o, txd_oe_o, rxd_o, reset_out_n_oe_o;
  wire bus_drv_o, term_on_o, rx_on_o, reg_on_o, reset_out_n_o;
  wire [`LMC_MODE_W-1:0] mode_o;
  always #25 clock_i = ~clock_i;
  lmc_far_model far_u (.host_txd_i(host_txd), .remote_dom_i(remote_dom), .txd_o_i(txd_o),
    .txd_oe_i(txd_oe_o), .bus_drv_i(bus_drv_o), .txd_pin_o(txd_i), .bus_o(bus_i),
    .prewake_o(prewake_threshold_i));
  lmc_mode_ctrl #(.RESET_CYC(RC), .DOM_CYC(DC)) dut_u (.clock_i, .rstn_i, .en_i,
    .en_float_i, .txd_i, .txd_o, .txd_oe_o, .rxd_o, .reset_out_n_o,
    .reset_out_n_oe_o, .bus_i, .prewake_threshold_i, .bus_drv_o, .term_on_o, .rx_on_o,
    .vcc_uv_i, .vs_uv_i, .reg_on_o, .mode_o);
  task tally_and_finish;
    if (miscompares == 0 && checks_done > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task cyc(input int n);
    repeat (n) @(posedge clock_i);
    #5;
  endtask
  task wait_mode(input [`LMC_MODE_W-1:0] m, input int lim);
    int i;
    i = 0;
    while (mode_o !== m && i < lim) begin
      cyc(1);
      i++;
    end
    `CHK("mode", m, mode_o)
    if (mode_o !== m) tally_and_finish;
    cyc(2);
  endtask
  task wake;
    remote_dom = 1;
    cyc(2100);
    remote_dom = 0;
    wait_mode(`LMC_ST_FAILSAFE, 20);
    `CHK("wake txd", 2'b10, {txd_oe_o, txd_o})
    `CHK("wake rxd reg term", 3'b011, {rxd_o, reg_on_o, term_on_o})
  endtask
  task t_power;
    `CHK("pwr", 3'b111, {mode_o == `LMC_ST_FAILSAFE, reset_out_n_oe_o, reg_on_o})
    `CHK("rst pin", 1'b0, reset_out_n_o)
    en_i = 1;
    cyc(RC - 10);
    `CHK("hold", `LMC_ST_FAILSAFE, mode_o)
    en_float_i = 1;
    cyc(30);
    `CHK("float", `LMC_ST_FAILSAFE, mode_o)
    `CHK("rst done", 1'b0, reset_out_n_oe_o)
    en_float_i = 0;
    wait_mode(`LMC_ST_NORMAL, 10);
    `CHK("rx on", 1'b1, rx_on_o)
  endtask
  task t_rx;
    remote_dom = 1;
    cyc(6);
    `CHK("rx dom", 1'b0, rxd_o)
    remote_dom = 0;
    host_txd = 0;
    cyc(6);
    `CHK("drv echo", 2'b10, {bus_drv_o, rxd_o})
    host_txd = 1;
    cyc(6);
    `CHK("rx rec", 1'b1, rxd_o)
  endtask
  task t_silent;
    remote_dom = 1;
    en_i = 0;
    wait_mode(`LMC_ST_SILENT, 90);
    `CHK("silent", 2'b11, {rxd_o, reg_on_o})
    remote_dom = 0;
    host_txd = 0;
    cyc(5);
    remote_dom = 1;
    cyc(2100);
    remote_dom = 0;
    cyc(10);
    `CHK("no wake", `LMC_ST_SILENT, mode_o)
    host_txd = 1;
    cyc(5);
    wake;
    en_i = 1;
    wait_mode(`LMC_ST_NORMAL, RC + 60);
  endtask
  task t_sleep;
    en_i = 0;
    cyc(40);
    host_txd = 0;
    wait_mode(`LMC_ST_SLEEP, 60);
    `CHK("sleep", 3'b001, {rxd_o, reg_on_o, reset_out_n_oe_o})
    remote_dom = 1;
    cyc(1500);
    `CHK("prewake", 1'b1, rx_on_o)
    remote_dom = 0;
    cyc(20);
    `CHK("short dom", `LMC_ST_SLEEP, mode_o)
    host_txd = 1;
    wake;
    en_i = 1;
    cyc(RC - 10);
    `CHK("wake hold", `LMC_ST_FAILSAFE, mode_o)
    wait_mode(`LMC_ST_NORMAL, 80);
  endtask
  task t_uv;
    vs_uv_i = 1;
    wait_mode(`LMC_ST_FAILSAFE, 10);
    `CHK("uv src", 3'b110, {txd_oe_o, txd_o, rxd_o})
    en_i = 0;
    wait_mode(`LMC_ST_SILENT, 90);
    vs_uv_i = 0;
    en_i = 1;
    wait_mode(`LMC_ST_NORMAL, 10);
    vcc_uv_i = 1;
    wait_mode(`LMC_ST_FAILSAFE, 10);
    `CHK("vcc uv", 1'b1, reset_out_n_oe_o)
    vcc_uv_i = 0;
    wait_mode(`LMC_ST_NORMAL, RC + 60);
  endtask
  task t_dom;
    host_txd = 0;
    cyc(DC + 20);
    `CHK("dom off", 1'b0, bus_drv_o)
    host_txd = 1;
    cyc(230);
    host_txd = 0;
    cyc(6);
    `CHK("drv back", 1'b1, bus_drv_o)
    cyc(100);
    en_i = 0;
    cyc(100);
    `CHK("stuck", 1'b0, mode_o == `LMC_ST_SLEEP)
    wait_mode(`LMC_ST_SLEEP, DC);
    wake;
    en_i = 1;
    wait_mode(`LMC_ST_NORMAL, RC + 60);
    `CHK("entry low", 1'b0, bus_drv_o)
    host_txd = 1;
    cyc(100);
    host_txd = 0;
    cyc(6);
    `CHK("short hi", 1'b0, bus_drv_o)
    host_txd = 1;
    cyc(230);
    host_txd = 0;
    cyc(6);
    `CHK("drv on", 1'b1, bus_drv_o)
    host_txd = 1;
  endtask
  initial begin
    cyc(10);
    rstn_i = 1;
    cyc(1);
    t_power;
    t_rx;
    t_silent;
    t_sleep;
    t_uv;
    t_dom;
    tally_and_finish;
  end
endmodule // lin_transceiver_mode_control_tb
